// ### common/port_drive_pkg.sv
// Purpose: constants for the port drive and ganged output block
// Assumes: 8-bit register port, one word per address
// Notes: offsets are local choices
package port_drive_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] OFS_DATA = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_DIR = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_DRIVE = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_SLEW = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_GANG = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_PINS = 3'h5;
    localparam logic [PORT_W-1:0] RST_ZERO = 8'h00;
    localparam int GANG_EN_BIT = 0;
endpackage : port_drive_pkg

// ### logic/port_drive_gang.sv
// Purpose: drive strength selection and ganged output for an 8-bit port
// Assumes: single clock, synchronous register port
// Notes: pad controls are registered outputs
//
// How it works
// - each drive strength bit picks low (0) or high (1) drive for its pin.
// - drive strength has no effect on pins configured as inputs.
// - gang control bits 7:1 are write-once pin selectors.
// - a pin is ganged only when its selector and the gang enable are both 1.
// - ganged pins copy pin 0 data, drive strength and slew rate.
// - gang control bit 0 is a write-once enable for ganged output.
// - with gang enable set, pin 0 is forced to be an output.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module port_drive_gang (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [port_drive_pkg::ADDR_W-1:0] addr,
    input wire logic [port_drive_pkg::PORT_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [port_drive_pkg::PORT_W-1:0] rdata,
    // pins
    input wire logic [port_drive_pkg::PORT_W-1:0] pin_in,
    output logic [port_drive_pkg::PORT_W-1:0] pin_out,
    output logic [port_drive_pkg::PORT_W-1:0] pin_oe_b,
    output logic [port_drive_pkg::PORT_W-1:0] pin_high_drive,
    output logic [port_drive_pkg::PORT_W-1:0] pin_slew
);
    import port_drive_pkg::*;

    logic [PORT_W-1:0] data_reg;
    logic [PORT_W-1:0] port_direction_register;
    logic [PORT_W-1:0] drive_strength_select;
    logic [PORT_W-1:0] slew_reg;
    logic [PORT_W-1:0] gang_output_control;
    logic gang_written;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [PORT_W-1:0] pick_src(
        input logic [PORT_W-1:0] sel,
        input logic [PORT_W-1:0] own,
        input logic [PORT_W-1:0] copy
    );
        return (sel & copy) | (~sel & own);
    endfunction : pick_src

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire wr_data = wr && (addr == OFS_DATA);
    wire wr_dir = wr && (addr == OFS_DIR);
    wire wr_drive = wr && (addr == OFS_DRIVE);
    wire wr_slew = wr && (addr == OFS_SLEW);
    wire wr_gang = wr && (addr == OFS_GANG) && !gang_written;

    wire gang_output_enable = gang_output_control[GANG_EN_BIT];
    wire [PORT_W-1:0] gang_pin_selects = {gang_output_control[PORT_W-1:1], 1'b0};
    wire [PORT_W-1:0] ganged = gang_output_enable ? gang_pin_selects : RST_ZERO;

    // effective controls
    wire [PORT_W-1:0] eff_dir = port_direction_register
        | {{(PORT_W-1){1'b0}}, gang_output_enable};
    wire [PORT_W-1:0] rep_data = {PORT_W{data_reg[0]}};
    wire [PORT_W-1:0] rep_drive = {PORT_W{drive_strength_select[0]}};
    wire [PORT_W-1:0] rep_slew = {PORT_W{slew_reg[0]}};
    wire [PORT_W-1:0] next_out = pick_src(ganged, data_reg, rep_data);
    wire [PORT_W-1:0] sel_drive = pick_src(ganged, drive_strength_select,
        rep_drive);
    // ganged pins drive even with their own direction bit clear
    wire [PORT_W-1:0] drives_out = eff_dir | ganged;
    wire [PORT_W-1:0] next_drive = sel_drive & drives_out;
    wire [PORT_W-1:0] next_slew = pick_src(ganged, slew_reg, rep_slew);
    wire [PORT_W-1:0] next_oe_b = ~drives_out;

    wire [PORT_W-1:0] next_rdata =
        !rd ? RST_ZERO :
        (addr == OFS_DATA) ? data_reg :
        (addr == OFS_DIR) ? port_direction_register :
        (addr == OFS_DRIVE) ? drive_strength_select :
        (addr == OFS_SLEW) ? slew_reg :
        (addr == OFS_GANG) ? gang_output_control :
        (addr == OFS_PINS) ? pin_in : RST_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            data_reg <= RST_ZERO;
            port_direction_register <= RST_ZERO;
            drive_strength_select <= RST_ZERO;
            slew_reg <= RST_ZERO;
        end else begin
            if (wr_data) data_reg <= wdata;
            if (wr_dir) port_direction_register <= wdata;
            if (wr_drive) drive_strength_select <= wdata;
            if (wr_slew) slew_reg <= wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gang_output_control <= RST_ZERO;
            gang_written <= 1'b0;
        end else if (wr_gang) begin
            gang_output_control <= wdata;
            gang_written <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= RST_ZERO;
            pin_out <= RST_ZERO;
            pin_oe_b <= ~RST_ZERO;
            pin_high_drive <= RST_ZERO;
            pin_slew <= RST_ZERO;
        end else begin
            rdata <= next_rdata;
            pin_out <= next_out;
            pin_oe_b <= next_oe_b;
            pin_high_drive <= next_drive;
            pin_slew <= next_slew;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_gang_write_once: assert property (@(posedge mclk) disable iff (!rst_b)
        gang_written && wr && addr == OFS_GANG |=> $stable(gang_output_control))
        else $error("gang control changed after first write");
    a_pin0_forced_out: assert property (@(posedge mclk) disable iff (!rst_b)
        gang_output_enable |=> !pin_oe_b[0])
        else $error("pin 0 not output while gang enabled");
    a_gang_copy_data: assert property (@(posedge mclk) disable iff (!rst_b)
        gang_output_enable && gang_output_control[1] |=> pin_out[1] == $past(data_reg[0]))
        else $error("ganged pin 1 data not copied from pin 0");
    a_gang_copy_drive: assert property (@(posedge mclk) disable iff (!rst_b)
        gang_output_enable && gang_output_control[7]
        |=> pin_high_drive[7] == $past(drive_strength_select[0]))
        else $error("ganged pin 7 drive not copied");
    a_gang_needs_en: assert property (@(posedge mclk) disable iff (!rst_b)
        !gang_output_enable && !port_direction_register[3] |=> pin_oe_b[3])
        else $error("pin driven without enable");
    a_drive_input_off: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[2] && !ganged[2] |=> !pin_high_drive[2])
        else $error("drive strength active on input");
    a_drive_select: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_drive && port_direction_register[4] && !ganged[4] && !wr_dir
        ##1 !ganged[4] |=> pin_high_drive[4] == $past(wdata[4], 2))
        else $error("drive strength not applied");
    a_gang_first_write: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_gang |=> gang_output_control == $past(wdata) ##1 gang_written)
        else $error("first gang write lost");
    a_gang_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !wr_gang |=> $stable(gang_output_control))
        else $error("gang control changed without a write");
    a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        !rd |=> rdata == RST_ZERO)
        else $error("read data not zero without read");

    // ganged data copies
    a_gang_data_2: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[2] |=> pin_out[2] == $past(data_reg[0]))
        else $error("ganged pin 2 data not copied");
    a_gang_data_3: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[3] |=> pin_out[3] == $past(data_reg[0]))
        else $error("ganged pin 3 data not copied");
    a_gang_data_4: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[4] |=> pin_out[4] == $past(data_reg[0]))
        else $error("ganged pin 4 data not copied");
    a_gang_data_5: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[5] |=> pin_out[5] == $past(data_reg[0]))
        else $error("ganged pin 5 data not copied");
    a_gang_data_6: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[6] |=> pin_out[6] == $past(data_reg[0]))
        else $error("ganged pin 6 data not copied");
    a_gang_data_7: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[7] |=> pin_out[7] == $past(data_reg[0]))
        else $error("ganged pin 7 data not copied");

    // ganged drive copies
    a_gang_drive_1: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[1] |=> pin_high_drive[1] == $past(drive_strength_select[0]))
        else $error("ganged pin 1 drive not copied");
    a_gang_drive_2: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[2] |=> pin_high_drive[2] == $past(drive_strength_select[0]))
        else $error("ganged pin 2 drive not copied");
    a_gang_drive_3: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[3] |=> pin_high_drive[3] == $past(drive_strength_select[0]))
        else $error("ganged pin 3 drive not copied");
    a_gang_drive_4: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[4] |=> pin_high_drive[4] == $past(drive_strength_select[0]))
        else $error("ganged pin 4 drive not copied");
    a_gang_drive_5: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[5] |=> pin_high_drive[5] == $past(drive_strength_select[0]))
        else $error("ganged pin 5 drive not copied");
    a_gang_drive_6: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[6] |=> pin_high_drive[6] == $past(drive_strength_select[0]))
        else $error("ganged pin 6 drive not copied");

    // ganged slew copies
    a_gang_slew_1: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[1] |=> pin_slew[1] == $past(slew_reg[0]))
        else $error("ganged pin 1 slew not copied");
    a_gang_slew_2: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[2] |=> pin_slew[2] == $past(slew_reg[0]))
        else $error("ganged pin 2 slew not copied");
    a_gang_slew_3: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[3] |=> pin_slew[3] == $past(slew_reg[0]))
        else $error("ganged pin 3 slew not copied");
    a_gang_slew_4: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[4] |=> pin_slew[4] == $past(slew_reg[0]))
        else $error("ganged pin 4 slew not copied");
    a_gang_slew_5: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[5] |=> pin_slew[5] == $past(slew_reg[0]))
        else $error("ganged pin 5 slew not copied");
    a_gang_slew_6: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[6] |=> pin_slew[6] == $past(slew_reg[0]))
        else $error("ganged pin 6 slew not copied");
    a_gang_slew_7: assert property (@(posedge mclk) disable iff (!rst_b)
        ganged[7] |=> pin_slew[7] == $past(slew_reg[0]))
        else $error("ganged pin 7 slew not copied");

    // pins outside the group keep their own data
    a_own_data_1: assert property (@(posedge mclk) disable iff (!rst_b)
        !ganged[1] |=> pin_out[1] == $past(data_reg[1]))
        else $error("pin 1 lost its own data");
    a_own_data_2: assert property (@(posedge mclk) disable iff (!rst_b)
        !ganged[2] |=> pin_out[2] == $past(data_reg[2]))
        else $error("pin 2 lost its own data");
    a_own_data_3: assert property (@(posedge mclk) disable iff (!rst_b)
        !ganged[3] |=> pin_out[3] == $past(data_reg[3]))
        else $error("pin 3 lost its own data");
    a_own_data_4: assert property (@(posedge mclk) disable iff (!rst_b)
        !ganged[4] |=> pin_out[4] == $past(data_reg[4]))
        else $error("pin 4 lost its own data");
    a_own_data_5: assert property (@(posedge mclk) disable iff (!rst_b)
        !ganged[5] |=> pin_out[5] == $past(data_reg[5]))
        else $error("pin 5 lost its own data");
    a_own_data_6: assert property (@(posedge mclk) disable iff (!rst_b)
        !ganged[6] |=> pin_out[6] == $past(data_reg[6]))
        else $error("pin 6 lost its own data");
    a_own_data_7: assert property (@(posedge mclk) disable iff (!rst_b)
        !ganged[7] |=> pin_out[7] == $past(data_reg[7]))
        else $error("pin 7 lost its own data");

    // input pins never get high drive
    a_input_off_0: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[0] && !ganged[0] |=> !pin_high_drive[0])
        else $error("drive strength active on input pin 0");
    a_input_off_1: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[1] && !ganged[1] |=> !pin_high_drive[1])
        else $error("drive strength active on input pin 1");
    a_input_off_3: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[3] && !ganged[3] |=> !pin_high_drive[3])
        else $error("drive strength active on input pin 3");
    a_input_off_4: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[4] && !ganged[4] |=> !pin_high_drive[4])
        else $error("drive strength active on input pin 4");
    a_input_off_5: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[5] && !ganged[5] |=> !pin_high_drive[5])
        else $error("drive strength active on input pin 5");
    a_input_off_6: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[6] && !ganged[6] |=> !pin_high_drive[6])
        else $error("drive strength active on input pin 6");
    a_input_off_7: assert property (@(posedge mclk) disable iff (!rst_b)
        !eff_dir[7] && !ganged[7] |=> !pin_high_drive[7])
        else $error("drive strength active on input pin 7");

    // own drive strength on plain outputs
    a_own_drive_0: assert property (@(posedge mclk) disable iff (!rst_b)
        eff_dir[0] |=> pin_high_drive[0] == $past(drive_strength_select[0]))
        else $error("pin 0 drive strength wrong");
    a_own_drive_1: assert property (@(posedge mclk) disable iff (!rst_b)
        eff_dir[1] && !ganged[1] |=> pin_high_drive[1] == $past(drive_strength_select[1]))
        else $error("pin 1 drive strength wrong");
    a_own_drive_2: assert property (@(posedge mclk) disable iff (!rst_b)
        eff_dir[2] && !ganged[2] |=> pin_high_drive[2] == $past(drive_strength_select[2]))
        else $error("pin 2 drive strength wrong");
    a_own_drive_3: assert property (@(posedge mclk) disable iff (!rst_b)
        eff_dir[3] && !ganged[3] |=> pin_high_drive[3] == $past(drive_strength_select[3]))
        else $error("pin 3 drive strength wrong");
    a_own_drive_5: assert property (@(posedge mclk) disable iff (!rst_b)
        eff_dir[5] && !ganged[5] |=> pin_high_drive[5] == $past(drive_strength_select[5]))
        else $error("pin 5 drive strength wrong");
    a_own_drive_6: assert property (@(posedge mclk) disable iff (!rst_b)
        eff_dir[6] && !ganged[6] |=> pin_high_drive[6] == $past(drive_strength_select[6]))
        else $error("pin 6 drive strength wrong");
    a_own_drive_7: assert property (@(posedge mclk) disable iff (!rst_b)
        eff_dir[7] && !ganged[7] |=> pin_high_drive[7] == $past(drive_strength_select[7]))
        else $error("pin 7 drive strength wrong");

    // no driving without direction or gang enable
    a_needs_en_1: assert property (@(posedge mclk) disable iff (!rst_b)
        !gang_output_enable && !port_direction_register[1] |=> pin_oe_b[1])
        else $error("pin 1 driven without enable");
    a_needs_en_2: assert property (@(posedge mclk) disable iff (!rst_b)
        !gang_output_enable && !port_direction_register[2] |=> pin_oe_b[2])
        else $error("pin 2 driven without enable");
    a_needs_en_4: assert property (@(posedge mclk) disable iff (!rst_b)
        !gang_output_enable && !port_direction_register[4] |=> pin_oe_b[4])
        else $error("pin 4 driven without enable");
    a_needs_en_5: assert property (@(posedge mclk) disable iff (!rst_b)
        !gang_output_enable && !port_direction_register[5] |=> pin_oe_b[5])
        else $error("pin 5 driven without enable");
    a_needs_en_6: assert property (@(posedge mclk) disable iff (!rst_b)
        !gang_output_enable && !port_direction_register[6] |=> pin_oe_b[6])
        else $error("pin 6 driven without enable");
    a_needs_en_7: assert property (@(posedge mclk) disable iff (!rst_b)
        !gang_output_enable && !port_direction_register[7] |=> pin_oe_b[7])
        else $error("pin 7 driven without enable");
endmodule : port_drive_gang

// ### verification/pin_load.sv
// Purpose: external loads hanging on the port pins
// Assumes: a driven pin reads back its own level
// Notes: undriven pins show the external level
`timescale 1ns/1ps
module pin_load (
    // pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_b,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    assign pin_in = (pin_out & ~pin_oe_b) | (ext_level & pin_oe_b);
endmodule : pin_load

// ### verification/port_drive_and_ganged_output_bench.sv
// Purpose: self-checking bench for the port drive block
// Assumes: direction bit 1 means output
// Notes: rows cover plain drive, gang cases by hand
`timescale 1ns/1ps
module port_drive_and_ganged_output_bench;
    import port_drive_pkg::*;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
    logic mclk = 0;
    logic rst_b = 0;
    logic wr = 0;
    logic rd = 0;
    logic [2:0] addr = 0;
    logic [7:0] wdata = 0;
    logic [7:0] rdata, pin_in, pin_out, pin_oe_b, pin_high_drive, pin_slew;
    int n_errors = 0;
    int samples_checked = 0;
    // dir, data, drive, slew, expected oe_b, expected high drive
    logic [7:0] rows [3][6] = '{'{8'hFF, 8'h5A, 8'hFF, 8'h0F, 8'h00, 8'hFF},
        '{8'h0F, 8'h3C, 8'hFF, 8'hF0, 8'hF0, 8'h0F}, '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00}};
    port_drive_gang DUT (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
        .pin_high_drive(pin_high_drive), .pin_slew(pin_slew));
    pin_load load (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext_level(8'hA0), .pin_in(pin_in));
    always #25 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        `CHK("rdata", e, rdata)
    endtask : rd_reg
    task automatic settle;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask : settle
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge mclk);
        `CHK("oe_b reset", 8'hFF, pin_oe_b)
        rst_b <= 1'b1;
        rd_reg(OFS_GANG, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr_reg(OFS_DIR, rows[i][0]);
            wr_reg(OFS_DATA, rows[i][1]);
            wr_reg(OFS_DRIVE, rows[i][2]);
            wr_reg(OFS_SLEW, rows[i][3]);
            settle;
            `CHK("oe_b", rows[i][4], pin_oe_b)
            `CHK("high_drive", rows[i][5], pin_high_drive)
            rd_reg(OFS_DRIVE, rows[i][2]);
        end
        wr_reg(OFS_DIR, 8'h00);
        wr_reg(OFS_DATA, 8'h01);
        wr_reg(OFS_DRIVE, 8'h01);
        wr_reg(OFS_SLEW, 8'h01);
        wr_reg(OFS_GANG, 8'h07);
        wr_reg(OFS_GANG, 8'hFF);
        rd_reg(OFS_GANG, 8'h07);
        settle;
        `CHK("gang oe_b", 8'hF8, pin_oe_b)
        `CHK("gang out", 8'h07, pin_out)
        `CHK("gang drive", 8'h07, pin_high_drive)
        `CHK("gang slew", 8'h07, pin_slew)
        rd_reg(OFS_PINS, 8'hA7);
        rd_reg(3'h7, 8'h00);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("oe_b re-reset", 8'hFF, pin_oe_b)
        rst_b <= 1'b1;
        rd_reg(OFS_GANG, 8'h00);
        wr_reg(OFS_DATA, 8'h01);
        wr_reg(OFS_GANG, 8'hFE);
        rd_reg(OFS_GANG, 8'hFE);
        settle;
        `CHK("no enable oe_b", 8'hFF, pin_oe_b)
        `CHK("no enable out", 8'h01, pin_out)
        end_of_test;
    end
endmodule : port_drive_and_ganged_output_bench
